// ---- core/bdm_pkg.sv ----
// package for the banked data memory addressing block
// assumes one core clock; the execute path presents one access per cycle
package bdm_pkg;
  localparam int BDM_ADDR_W = 12;
  localparam int BDM_BANK_W = 4;
  localparam int BDM_OFS_W = 8;
  localparam int BDM_SPACE_BYTES = 4096;
  localparam int BDM_BANK_BYTES = 256;
  localparam int BDM_BANKS_SMALL = 4;
  localparam int BDM_BANKS_LARGE = 8;
  localparam logic [3:0] BDM_CTRL_BANK = 4'hf;
  localparam logic [7:0] BDM_ACCESS_SPLIT = 8'h60;
  localparam logic [11:0] BDM_CTRL_BASE = 12'hf60;
  localparam logic [11:0] BDM_BANK_PTR_ADDR = 12'hfe0;
  localparam logic [11:0] BDM_PC_LOW_ADDR = 12'hff9;
  localparam logic [3:0] BDM_BANK_PTR_RESET = 4'h0;
  localparam logic [7:0] BDM_XACCESS_SPLIT = 8'h60;
  typedef enum logic [1:0] {BDM_MODE_ACCESS, BDM_MODE_BANKED, BDM_MODE_FULL} bdm_mode_t;
endpackage : bdm_pkg

// ---- core/bdm_mem_if.sv ----
// carrier between the address block and its storage array
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface bdm_mem_if #(parameter int AW = 11);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : bdm_mem_if

// ---- core/bdm_ram.sv ----
// general ram storage array with registered read data
// assumes address is resolved combinationally by the owner
`timescale 1ns/1ps
module bdm_ram
  import bdm_pkg::*;
#(
  parameter int AW = 11
)
(
  input wire logic clk,
  bdm_mem_if.mem port
);
  logic [7:0] mem_ff [0:(1<<AW)-1];
  logic [7:0] rdata_ff;

  // no reset on the array: contents survive every reset
  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      mem_ff[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata_ff <= mem_ff[port.addr];
  end

  assign port.rdata = rdata_ff;
endmodule : bdm_ram

// ---- core/bdm_core.sv ----
// data memory address generation, bank pointer and storage routing
// assumes decode presents one access per cycle; writes land on the clock edge
`timescale 1ns/1ps
module bdm_core
  import bdm_pkg::*;
#(
  parameter int NUM_BANKS = BDM_BANKS_LARGE
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_full,
  input wire logic acc_abit,
  input wire logic [7:0] acc_operand,
  input wire logic [11:0] acc_full_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic extended_isa_enable,
  input wire logic load_bank_literal,
  input wire logic [7:0] bank_literal,
  input wire logic [7:0] ctrl_rdata,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [11:0] eff_addr,
  output logic [7:0] bank_pointer,
  output logic ctrl_we,
  output logic ctrl_re,
  output logic [7:0] ctrl_addr,
  output logic [7:0] ctrl_wdata,
  output logic program_counter_low_we,
  output logic [7:0] program_counter_low_wdata
);
  // only the two documented sizes are supported
  if (NUM_BANKS != BDM_BANKS_SMALL && NUM_BANKS != BDM_BANKS_LARGE)
  begin : g_bad_banks
    $error("bdm_core: NUM_BANKS must be 4 or 8");
  end

  localparam int RAM_AW = $clog2(NUM_BANKS * BDM_BANK_BYTES);

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] bank_ptr_ff;
  logic [11:0] nxt_addr;
  bdm_mode_t mode;
  logic ram_hit;
  logic ctrl_hit;
  logic bptr_hit;
  logic [7:0] split;
  logic pc_hit;
  logic wr_take;
  logic rd_take;

  bdm_mem_if #(.AW(RAM_AW)) ram_bus ();

  bdm_ram #(.AW(RAM_AW)) u_ram
  (
    .clk(clk),
    .port(ram_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode select
  always_comb
  begin
    if (acc_full)
    begin
      mode = BDM_MODE_FULL;
    end
    else if (acc_abit)
    begin
      mode = BDM_MODE_BANKED;
    end
    else
    begin
      mode = BDM_MODE_ACCESS;
    end
  end

  // extended remap itself lives elsewhere; the split point is selected here, but both choices are 8'h60 so it never moves
  assign split = extended_isa_enable ? BDM_XACCESS_SPLIT : BDM_ACCESS_SPLIT;

  // one resolved address feeds both read and write, no staging
  always_comb
  begin
    case (mode)
      BDM_MODE_FULL:
      begin
        nxt_addr = acc_full_addr;
      end
      BDM_MODE_BANKED:
      begin
        nxt_addr = {bank_ptr_ff, acc_operand};
      end
      default:
      begin
        if (acc_operand < split)
        begin
          nxt_addr = {4'h0, acc_operand};
        end
        else
        begin
          nxt_addr = {BDM_CTRL_BANK, acc_operand};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign wr_take = acc_valid && acc_write;
  assign rd_take = acc_valid && !acc_write;

  // first match wins; the pointer and pc low sit inside the control area
  always_comb
  begin
    ram_hit = 1'b0;
    ctrl_hit = 1'b0;
    bptr_hit = 1'b0;
    pc_hit = 1'b0;
    if (nxt_addr == BDM_BANK_PTR_ADDR)
    begin
      bptr_hit = 1'b1;
    end
    else if (nxt_addr == BDM_PC_LOW_ADDR)
    begin
      ctrl_hit = 1'b1;
      pc_hit = 1'b1;
    end
    else if (nxt_addr >= BDM_CTRL_BASE)
    begin
      ctrl_hit = 1'b1;
    end
    else if (32'(nxt_addr[11:8]) < NUM_BANKS)
    begin
      ram_hit = 1'b1;
    end
  end

  assign ram_bus.we = wr_take && ram_hit;
  assign ram_bus.addr = nxt_addr[RAM_AW-1:0];
  assign ram_bus.wdata = acc_wdata;

  ////////////////////////////////////////////////////////////////////////
  // bank pointer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bank_ptr_ff <= BDM_BANK_PTR_RESET;
    end
    else if (load_bank_literal)
    begin
      bank_ptr_ff <= bank_literal[3:0];
    end
    else if (acc_valid && acc_write && bptr_hit)
    begin
      bank_ptr_ff <= acc_wdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bank_pointer <= 8'h00;
    end
    else if (load_bank_literal)
    begin
      bank_pointer <= {4'h0, bank_literal[3:0]};
    end
    else if (acc_valid && acc_write && bptr_hit)
    begin
      bank_pointer <= {4'h0, acc_wdata[3:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control area strobes, registered toward the peripherals
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_we <= 1'b0;
      ctrl_re <= 1'b0;
    end
    else
    begin
      ctrl_we <= wr_take && ctrl_hit;
      ctrl_re <= rd_take && ctrl_hit;
    end
  end

  // offset and data follow every cycle; only the strobes qualify them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_addr <= 8'h00;
      ctrl_wdata <= 8'h00;
    end
    else
    begin
      ctrl_addr <= nxt_addr[7:0];
      ctrl_wdata <= acc_wdata;
    end
  end

  // resolved address visible one cycle after the request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      eff_addr <= 12'h000;
    end
    else
    begin
      eff_addr <= nxt_addr;
    end
  end

  // any addressing mode can reach pc low, not only banked
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      program_counter_low_we <= 1'b0;
    end
    else
    begin
      program_counter_low_we <= wr_take && pc_hit;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      program_counter_low_wdata <= 8'h00;
    end
    else
    begin
      program_counter_low_wdata <= acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read return; selection remembered for the registered ram output
  logic sel_ram_ff;
  logic sel_bptr_ff;
  logic sel_ctrl_ff;
  logic rd_pend_ff;

  // a read waits one cycle while the ram array registers its answer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_pend_ff <= 1'b0;
    end
    else
    begin
      rd_pend_ff <= rd_take;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sel_ram_ff <= 1'b0;
      sel_bptr_ff <= 1'b0;
      sel_ctrl_ff <= 1'b0;
    end
    else
    begin
      sel_ram_ff <= ram_hit;
      sel_bptr_ff <= bptr_hit;
      sel_ctrl_ff <= ctrl_hit;
    end
  end

  // zero data still comes back with rd_valid so the alu sets its flags
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_pend_ff;
      if (!rd_pend_ff)
      begin
        rd_data <= 8'h00;
      end
      else if (sel_ram_ff)
      begin
        rd_data <= ram_bus.rdata;
      end
      else if (sel_bptr_ff)
      begin
        rd_data <= bank_pointer;
      end
      else if (sel_ctrl_ff)
      begin
        rd_data <= ctrl_rdata;
      end
      else
      begin
        rd_data <= 8'h00;
      end
    end
  end
endmodule : bdm_core

// ---- verif/bdm_periph.sv ----
// control area stand-in for the bench
// assumes strobes from bdm_core, one clock
`timescale 1ns/1ps
module bdm_periph
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ctrl_we,
  input wire logic ctrl_re,
  input wire logic [7:0] ctrl_addr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata
);
  logic [7:0] regs_ff [0:255];
  logic [7:0] idle_ff;
  wire logic hole = ctrl_addr inside {8'h9c, 8'hb0, 8'hd4};
  always_ff @(posedge clk)
    if (ctrl_we && !hole)
      regs_ff[ctrl_addr] <= ctrl_wdata;
  // answers within the ctrl_re cycle, where the core samples; idle shows the inverse
  always_ff @(posedge clk)
    idle_ff <= reset ? 8'h00 : ~ctrl_rdata;
  assign ctrl_rdata = ctrl_re ? (hole ? 8'h00 : regs_ff[ctrl_addr]) : idle_ff;
endmodule : bdm_periph

// ---- verif/bdm_core_asserts.sv ----
// port checker for bdm_core
// assumes one clock, async high reset
`timescale 1ns/1ps
module bdm_core_asserts
#(
  parameter int NUM_BANKS = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_full,
  input wire logic acc_abit,
  input wire logic [7:0] acc_operand,
  input wire logic [11:0] acc_full_addr,
  input wire logic load_bank_literal,
  input wire logic [7:0] bank_literal,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic [11:0] eff_addr,
  input wire logic [7:0] bank_pointer,
  input wire logic program_counter_low_we
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic bk = acc_valid && !acc_full && acc_abit;
  wire logic ab = acc_valid && !acc_full && !acc_abit;
  AST_RD_DONE: assert property (acc_valid && !acc_write |-> ##[1:3] rd_valid) else $error("read lost");
  AST_BANKED: assert property (bk |=> {4'h0, eff_addr[11:8]} == $past(bank_pointer) &&
    eff_addr[7:0] == $past(acc_operand)) else $error("banked address");
  AST_ACC_LO: assert property (ab && acc_operand < 8'h60 |=> eff_addr == {4'h0, $past(acc_operand)})
    else $error("access low");
  AST_ACC_HI: assert property (ab && acc_operand >= 8'h60 |=> eff_addr == {4'hf, $past(acc_operand)})
    else $error("access high");
  AST_FULL: assert property (acc_valid && acc_full |=> eff_addr == $past(acc_full_addr)) else $error("full");
  AST_BP_HI: assert property (bank_pointer[7:4] == 4'h0) else $error("pointer top");
  AST_LIT: assert property (load_bank_literal |=> bank_pointer[3:0] == $past(bank_literal) % 16)
    else $error("literal");
  AST_PCL: assert property (bk && acc_write && bank_pointer == 8'h0f && acc_operand == 8'hf9
    |=> program_counter_low_we) else $error("pc low");
  AST_UNIMP: assert property (acc_valid && !acc_write && acc_full && acc_full_addr < 12'hf60 &&
    acc_full_addr[11:8] >= NUM_BANKS |-> ##[1:3] (rd_valid && rd_data == 8'h00)) else $error("unimpl");
endmodule : bdm_core_asserts
bind bdm_core bdm_core_asserts #(.NUM_BANKS(NUM_BANKS)) i_bdm_core_asserts (.*);

// ---- verif/bdm_core_bench.sv ----
// bench for bdm_core, small build, random and corner accesses
// assumes bdm_periph answers the control area
`timescale 1ns/1ps
module bdm_core_bench;
  import bdm_pkg::*;
  localparam int NB = BDM_BANKS_SMALL;
  logic clk = 1'b0, reset = 1'b1, acc_valid = 1'b0, acc_write = 1'b0, acc_full = 1'b0, acc_abit = 1'b0;
  logic extended_isa_enable = 1'b0, load_bank_literal = 1'b0, rd_valid, ctrl_we, ctrl_re, program_counter_low_we;
  logic [7:0] acc_operand = 8'h00, acc_wdata = 8'h00, bank_literal = 8'h00, ctrl_rdata, rd_data, bank_pointer;
  logic [7:0] ctrl_addr, ctrl_wdata, program_counter_low_wdata;
  logic [11:0] acc_full_addr = 12'h000, eff_addr;
  logic [7:0] mdl [0:4095];
  logic [3:0] bp = 4'h0;
  logic [31:0] r = 32'hbc0f;
  int error_cnt = 0, checks_done = 0;
  always #50 clk = ~clk;
  bdm_core #(.NUM_BANKS(NB)) i_bdm_core (.*);
  bdm_periph i_bdm_periph (.*);
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(logic [11:0] s, logic [11:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic bit live(logic [11:0] a);
    return a >= BDM_CTRL_BASE ? !(a inside {12'hf9c, 12'hfb0, 12'hfd4}) : a[11:8] < NB;
  endfunction : live
  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic acc(logic w, f, a, logic [7:0] op, logic [11:0] fa, logic [7:0] wd, logic lb, logic [7:0] lit);
    logic [11:0] ea;
    logic [7:0] ex;
    int n;
    @(negedge clk);
    {acc_valid, acc_write, acc_full, acc_abit, acc_operand, acc_full_addr} = {1'b1, w, f, a, op, fa};
    {acc_wdata, load_bank_literal, bank_literal, extended_isa_enable} = {wd, lb, lit, r[3]};
    ea = f ? fa : a ? {bp, op} : {op < 8'h60 ? 4'h0 : 4'hf, op};
    ex = ea == BDM_BANK_PTR_ADDR ? {4'h0, bp} : live(ea) ? mdl[ea] : 8'h00;
    if (w && ea == BDM_BANK_PTR_ADDR)
      bp = wd[3:0];
    else if (w && live(ea))
      mdl[ea] = wd;
    if (lb)
      bp = lit[3:0];
    @(negedge clk);
    {acc_valid, load_bank_literal} = 2'b00;
    chk(eff_addr, ea);
    chk({program_counter_low_we, program_counter_low_wdata}, {w && ea == BDM_PC_LOW_ADDR, wd});
    chk(bank_pointer, {4'h0, bp});
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++)
      @(negedge clk);
    if (!w && n == 4)
    begin
      error_cnt++;
      close_out();
    end
    else if (!w && !$isunknown(ex))
      chk(rd_data, ex);
  endtask : acc
  initial
  begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    acc(1, 1, 0, 0, 12'h000, 8'h5a, 1, 8'hff);
    acc(1, 0, 1, 8'hf9, 0, 8'h34, 0, 0);
    acc(1, 0, 0, 8'h5f, 0, 8'ha5, 0, 0);
    acc(0, 0, 0, 8'h5f, 0, 0, 0, 0);
    acc(1, 1, 0, 0, 12'h400, 8'h77, 0, 0);
    acc(0, 1, 0, 0, 12'h400, 0, 0, 0);
    acc(0, 1, 0, 0, 12'hf9c, 0, 0, 0);
    acc(1, 1, 0, 0, 12'hfe0, 8'hff, 1, 8'h02);
    repeat (400)
    begin
      r = xs(r);
      acc(r[0], r[1], r[2], r[15:8] & 8'hc3, {r[27:24], r[23:16] & 8'hc3}, r[31:24], r[30] & r[29], r[11:4]);
    end
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    bp = 4'h0;
    acc(0, 0, 0, 8'h5f, 0, 0, 0, 0);
    acc(0, 1, 0, 0, 12'h000, 0, 0, 0);
    close_out();
  end
endmodule : bdm_core_bench
